// file: design/seq_pkg.sv
// constants for the instruction sequencer of the two-stack processor
package seq_pkg;
	localparam int INSN_W    = 32;
	localparam int OPC_W     = 9;
	localparam int FLD_W     = 21;
	localparam int LIT_W     = 23;
	localparam int SLIT_W    = 6;
	localparam int STEP_W    = 3;
	localparam int UC_AW     = OPC_W + STEP_W;
	localparam int UC_DEPTH  = 4096;
	localparam int RS_DEPTH  = 32;
	localparam int RS_MIN    = 32;
	localparam int RS_MAX    = 256;
	// instruction word fields
	localparam int OPC_MSB   = 31;
	localparam int OPC_LSB   = 23;
	localparam int FLD_MSB   = 22;
	localparam int FLD_LSB   = 2;
	localparam int CTL_MSB   = 1;
	localparam int CTL_LSB   = 0;
	// dual opcode word fields
	localparam int OPA_MSB   = 31;
	localparam int OPA_LSB   = 23;
	localparam int LITA_MSB  = 22;
	localparam int LITA_LSB  = 17;
	localparam int OPB_MSB   = 16;
	localparam int OPB_LSB   = 8;
	localparam int LITB_MSB  = 7;
	localparam int LITB_LSB  = 2;
	// control field codes
	localparam logic [1:0] CTL_SEQ  = 2'h0;
	localparam logic [1:0] CTL_CALL = 2'h1;
	localparam logic [1:0] CTL_RET  = 2'h2;
	localparam logic [1:0] CTL_DUAL = 2'h3;
	// microword fields
	localparam int UW_LAST   = 31;
	localparam int UW_DLOAD  = 30;
	localparam int UW_BSEL_M = 29;
	localparam int UW_BSEL_L = 28;
	localparam int UW_SIZE_M = 27;
	localparam int UW_SIZE_L = 26;
	// access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	// tester register selects
	localparam logic [2:0] TREG_NAR   = 3'h0;
	localparam logic [2:0] TREG_UIR   = 3'h1;
	localparam logic [2:0] TREG_DADDR = 3'h2;
	localparam logic [2:0] TREG_BASE  = 3'h4;
	// reset values and steps
	localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
	localparam logic [31:0] UIR_RESET  = 32'h0000_0000;
	localparam logic [31:0] ADDR_STEP  = 32'h0000_0004;
	localparam logic [STEP_W-1:0] STEP_LAST = 3'h7;
	typedef enum logic [1:0] {EX_IDLE, EX_OP_A, EX_OP_B} ex_state_t;
endpackage

// file: design/insn_sequencer.sv
// fetch, decode and microcode sequencing front end
`timescale 1ns/1ps
module insn_sequencer
	import seq_pkg::*;
#(
	parameter int RS_DEPTH_P = seq_pkg::RS_DEPTH,
	parameter int UC_DEPTH_P = seq_pkg::UC_DEPTH
) (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	output logic [31:0]                    imem_addr_o,
	output logic                           imem_req_o,
	input  wire logic [seq_pkg::INSN_W-1:0] imem_rdata_i,
	output logic [seq_pkg::OPC_W-1:0]      op_o,
	output logic [seq_pkg::LIT_W-1:0]      lit_o,
	output logic [31:0]                    uir_o,
	output logic [31:0]                    data_addr_o,
	output logic [1:0]                     data_size_o,
	output logic                           data_req_o,
	input  wire logic                      base_wr_i,
	input  wire logic [1:0]                base_sel_i,
	input  wire logic [31:0]               base_wdata_i,
	input  wire logic                      uc_wr_i,
	input  wire logic [seq_pkg::UC_AW-1:0] uc_waddr_i,
	input  wire logic [31:0]               uc_wdata_i,
	input  wire logic [seq_pkg::UC_AW-1:0] uc_raddr_i,
	output logic [31:0]                    uc_rdata_o,
	input  wire logic                      test_pin_i,
	input  wire logic                      test_uir_wr_i,
	input  wire logic                      test_step_i,
	input  wire logic                      test_wr_i,
	input  wire logic [2:0]                test_sel_i,
	input  wire logic [31:0]               test_data_i,
	output logic [31:0]                    test_rdata_o,
	output logic                           test_active_o
);
	import seq_pkg::*;

	localparam int RSP_W = $clog2(RS_DEPTH_P);

	////////////////////////////////////////////////////////////////////////
	// state

	ex_state_t             ex_state;
	logic [31:0]           nar;
	logic [31:0]           ibuf;
	logic                  ibuf_valid;
	logic [1:0]            fpipe;
	logic [STEP_W-1:0]     step;
	logic                  dual_pend;
	logic [OPC_W-1:0]      opb_hold;
	logic [LIT_W-1:0]      litb_hold;
	logic [31:0]           ucode [UC_DEPTH_P];
	logic [31:0]           rstack [RS_DEPTH_P];
	logic [RSP_W-1:0]      rsp;
	logic [31:0]           base [1:3];
	logic [1:0]            tpin_meta;
	logic                  test_mode;

	////////////////////////////////////////////////////////////////////////
	// decode

	logic [1:0]            ctl;
	logic [OPC_W-1:0]      dec_op;
	logic [FLD_W-1:0]      dec_fld;
	logic [LIT_W-1:0]      dec_lit;
	logic [OPC_W-1:0]      dec_opb;
	logic [LIT_W-1:0]      dec_litb;
	logic [31:0]           call_target;
	logic [31:0]           rs_top;
	logic                  dispatch;
	logic                  boot;
	logic [31:0]           fetch_addr;
	logic [UC_AW-1:0]      uc_index;
	logic [31:0]           uc_word;
	logic                  op_done;
	logic [31:0]           act_word;
	logic                  act_valid;
	logic [31:0]           act_base;
	logic [31:0]           next_daddr;

	always_comb begin
		ctl      = ibuf[CTL_MSB:CTL_LSB];
		dec_fld  = ibuf[FLD_MSB:FLD_LSB];
		dec_op   = ibuf[OPC_MSB:OPC_LSB];
		dec_lit  = {{(LIT_W-FLD_W){dec_fld[FLD_W-1]}}, dec_fld};
		dec_opb  = ibuf[OPB_MSB:OPB_LSB];
		dec_litb = {{(LIT_W-SLIT_W){ibuf[LITB_MSB]}},
			ibuf[LITB_MSB:LITB_LSB]};
		if (ctl == CTL_DUAL) begin
			dec_op  = ibuf[OPA_MSB:OPA_LSB];
			dec_lit = {{(LIT_W-SLIT_W){ibuf[LITA_MSB]}},
				ibuf[LITA_MSB:LITA_LSB]};
		end
	end

	// word-aligned target: the field is the word index
	assign call_target = {9'h000, dec_fld, 2'h0};
	assign rs_top      = rstack[rsp - RSP_W'(1)];

	// decoding only when idle keeps the return stack consistent
	assign dispatch = (ex_state == EX_IDLE) && ibuf_valid && !test_mode;
	assign boot     = (ex_state == EX_IDLE) && !ibuf_valid && (fpipe == 2'h0)
		&& !test_mode;

	always_comb begin
		fetch_addr = nar;
		if (dispatch) begin
			case (ctl)
			CTL_CALL: fetch_addr = call_target;
			CTL_RET:  fetch_addr = rs_top;
			default:  fetch_addr = nar;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fetch: request, one wait clock, capture on the second clock

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			imem_req_o  <= 1'b0;
			imem_addr_o <= RESET_ADDR;
			fpipe       <= 2'h0;
		end else begin
			imem_req_o <= dispatch || boot;
			fpipe      <= {fpipe[0], dispatch || boot};
			if (dispatch || boot)
				imem_addr_o <= fetch_addr;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ibuf       <= 32'h0000_0000;
			ibuf_valid <= 1'b0;
		end else if (fpipe[1]) begin
			ibuf       <= imem_rdata_i;
			ibuf_valid <= 1'b1;
		end else if (dispatch) begin
			ibuf_valid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			nar <= RESET_ADDR;
		else if (test_mode && test_wr_i && test_sel_i == TREG_NAR)
			nar <= test_data_i;
		else if (dispatch || boot)
			nar <= fetch_addr + ADDR_STEP;
	end

	////////////////////////////////////////////////////////////////////////
	// return stack

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rsp <= '0;
		end else if (dispatch && ctl == CTL_CALL) begin
			rsp <= rsp + RSP_W'(1);
		end else if (dispatch && ctl == CTL_RET) begin
			rsp <= rsp - RSP_W'(1);
		end
	end

	// stack storage has no reset, so it sits apart from the pointer
	always_ff @(posedge sys_clk_i) begin
		if (dispatch && ctl == CTL_CALL)
			rstack[rsp] <= nar;
	end

	////////////////////////////////////////////////////////////////////////
	// microcode sequencing

	assign uc_index = {op_o, step};
	assign uc_word  = ucode[uc_index];
	assign op_done  = uc_word[UW_LAST] || (step == STEP_LAST);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ex_state  <= EX_IDLE;
			step      <= '0;
			op_o      <= '0;
			lit_o     <= '0;
			dual_pend <= 1'b0;
			opb_hold  <= '0;
			litb_hold <= '0;
		end else begin
			case (ex_state)
			EX_IDLE: begin
				if (dispatch) begin
					ex_state  <= EX_OP_A;
					step      <= '0;
					op_o      <= dec_op;
					lit_o     <= dec_lit;
					dual_pend <= (ctl == CTL_DUAL);
					opb_hold  <= dec_opb;
					litb_hold <= dec_litb;
				end
			end
			EX_OP_A, EX_OP_B: begin
				if (!op_done) begin
					step <= step + STEP_W'(1);
				end else if (ex_state == EX_OP_A && dual_pend) begin
					ex_state <= EX_OP_B;
					step     <= '0;
					op_o     <= opb_hold;
					lit_o    <= litb_hold;
				end else begin
					ex_state <= EX_IDLE;
				end
			end
			default: ex_state <= EX_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			uir_o <= UIR_RESET;
		else if (test_mode && test_uir_wr_i)
			uir_o <= test_data_i;
		else if (test_mode && test_wr_i && test_sel_i == TREG_UIR)
			uir_o <= test_data_i;
		else if (!test_mode && ex_state != EX_IDLE)
			uir_o <= uc_word;
	end

	// writes are taken at any time; a word being executed changes next clock
	always_ff @(posedge sys_clk_i) begin
		if (uc_wr_i)
			ucode[uc_waddr_i] <= uc_wdata_i;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			uc_rdata_o <= 32'h0000_0000;
		else
			uc_rdata_o <= ucode[uc_raddr_i];
	end

	////////////////////////////////////////////////////////////////////////
	// data address

	assign act_word  = test_mode ? uir_o : uc_word;
	assign act_valid = test_mode ? test_step_i : (ex_state != EX_IDLE);
	assign act_base  = (act_word[UW_BSEL_M:UW_BSEL_L] == 2'h0) ? 32'h0000_0000
		: base[act_word[UW_BSEL_M:UW_BSEL_L]];

	always_comb begin
		next_daddr = act_base + {{(32-LIT_W){lit_o[LIT_W-1]}}, lit_o};
		case (act_word[UW_SIZE_M:UW_SIZE_L])
		SIZE_WORD: next_daddr[1:0] = 2'h0;
		SIZE_HALF: next_daddr[0]   = 1'b0;
		default:   ;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_addr_o <= 32'h0000_0000;
			data_size_o <= SIZE_WORD;
			data_req_o  <= 1'b0;
		end else begin
			data_req_o <= act_valid && act_word[UW_DLOAD];
			if (test_mode && test_wr_i && test_sel_i == TREG_DADDR) begin
				data_addr_o <= test_data_i;
			end else if (act_valid && act_word[UW_DLOAD]) begin
				data_addr_o <= next_daddr;
				data_size_o <= act_word[UW_SIZE_M:UW_SIZE_L];
			end
		end
	end

	// base zero is not stored, so no write can make it nonzero
	generate
		for (genvar b = 1; b < 4; b++) begin : g_base
			always_ff @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i)
					base[b] <= 32'h0000_0000;
				else if (test_mode && test_wr_i
					&& test_sel_i == (TREG_BASE | 3'(b)))
					base[b] <= test_data_i;
				else if (base_wr_i && base_sel_i == 2'(b))
					base[b] <= base_wdata_i;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// test access

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tpin_meta     <= 2'h0;
			test_mode     <= 1'b0;
			test_active_o <= 1'b0;
		end else begin
			tpin_meta     <= {tpin_meta[0], test_pin_i};
			test_mode     <= tpin_meta[1];
			test_active_o <= tpin_meta[1];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			test_rdata_o <= 32'h0000_0000;
		end else begin
			case (test_sel_i)
			TREG_NAR:   test_rdata_o <= nar;
			TREG_UIR:   test_rdata_o <= uir_o;
			TREG_DADDR: test_rdata_o <= data_addr_o;
			3'h5:       test_rdata_o <= base[1];
			3'h6:       test_rdata_o <= base[2];
			3'h7:       test_rdata_o <= base[3];
			default:    test_rdata_o <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_call_target;
		@(posedge sys_clk_i) disable iff (rst_i)
		dispatch && ctl == CTL_CALL |=> imem_addr_o == $past(call_target)
			&& imem_addr_o[1:0] == 2'h0;
	endproperty
	a_call_target: assert property (p_call_target)
		else $error("call fetch address wrong");

	property p_seq_next;
		@(posedge sys_clk_i) disable iff (rst_i)
		dispatch && ctl == CTL_SEQ |=> nar == imem_addr_o + ADDR_STEP;
	endproperty
	a_seq_next: assert property (p_seq_next)
		else $error("sequential next address wrong");

	property p_ret_pop;
		@(posedge sys_clk_i) disable iff (rst_i)
		dispatch && ctl == CTL_RET |=> imem_addr_o == $past(rs_top)
			&& ex_state == EX_OP_A;
	endproperty
	a_ret_pop: assert property (p_ret_pop)
		else $error("return did not fetch stack top");

	property p_fetch_two;
		@(posedge sys_clk_i) disable iff (rst_i)
		imem_req_o |=> !ibuf_valid ##1 ibuf_valid;
	endproperty
	a_fetch_two: assert property (p_fetch_two)
		else $error("fetch not captured after two clocks");

	property p_dual_pace;
		@(posedge sys_clk_i) disable iff (rst_i)
		ex_state == EX_OP_A && dual_pend && uc_word[UW_LAST]
			|=> ex_state == EX_OP_B && op_o == $past(opb_hold);
	endproperty
	a_dual_pace: assert property (p_dual_pace)
		else $error("second opcode not started next clock");

	property p_base_zero;
		@(posedge sys_clk_i) disable iff (rst_i)
		act_valid && act_word[UW_DLOAD] && act_word[UW_BSEL_M:UW_BSEL_L] == 2'h0
			&& act_word[UW_SIZE_M:UW_SIZE_L] == SIZE_BYTE && !test_wr_i
			|=> data_addr_o == {{(32-LIT_W){$past(lit_o[LIT_W-1])}},
				$past(lit_o)};
	endproperty
	a_base_zero: assert property (p_base_zero)
		else $error("base zero did not read as zero");

	property p_align;
		@(posedge sys_clk_i) disable iff (rst_i)
		data_req_o |-> (data_size_o != SIZE_WORD || data_addr_o[1:0] == 2'h0)
			&& (data_size_o != SIZE_HALF || data_addr_o[0] == 1'b0);
	endproperty
	a_align: assert property (p_align)
		else $error("misaligned data address");

	property p_test_uir;
		@(posedge sys_clk_i) disable iff (rst_i)
		test_mode && test_uir_wr_i |=> uir_o == $past(test_data_i);
	endproperty
	a_test_uir: assert property (p_test_uir)
		else $error("tester microword not loaded");

	property p_test_hold;
		@(posedge sys_clk_i) disable iff (rst_i)
		test_mode && !test_uir_wr_i && !test_wr_i |=> $stable(uir_o);
	endproperty
	a_test_hold: assert property (p_test_hold)
		else $error("microword changed without tester");

	property p_ucode_base;
		@(posedge sys_clk_i) disable iff (rst_i)
		dispatch |=> uc_index == {$past(dec_op), 3'h0};
	endproperty
	a_ucode_base: assert property (p_ucode_base)
		else $error("microcode base not opcode times eight");
endmodule

// file: testbench/prog_mem_model.sv
// off-chip program memory with a two-clock access for the sequencer bench
`timescale 1ns/1ps
module prog_mem_model (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] addr_i,
	input  wire logic        req_i,
	output logic      [31:0] rdata_o
);
	logic [31:0] mem [64];
	logic        busy;
	logic [5:0]  widx;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy <= 1'b0;
			widx <= 6'h00;
		end else begin
			busy <= req_i;
			if (req_i) begin
				widx <= addr_i[7:2];
			end
		end
	end

	// word stands only in the second clock; inverted outside it so an
	// early or late sample cannot pass by luck
	always_comb rdata_o = busy ? mem[widx] : ~mem[widx];
endmodule

// file: testbench/stack_cpu_instruction_sequencer_tb.sv
// self-checking bench for the instruction sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	miscompares++; $display("Error %s exp %h got %h", nm, e, g); end end
module stack_cpu_instruction_sequencer_tb;
	import seq_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] ia, ir, uir, da, trd, ucr;
	logic        ireq, dreq, tact;
	logic [8:0]  op;
	logic [22:0] lit;
	logic [1:0]  dsz;
	logic        bwr = 1'b0;
	logic [1:0]  bsel = 2'h0;
	logic [31:0] bwd = 32'h0;
	logic        ucw = 1'b0;
	logic [11:0] ucwa = 12'h0;
	logic [11:0] ucra = 12'h0;
	logic [31:0] ucwd = 32'h0;
	logic        tpin = 1'b0;
	logic        tuw = 1'b0;
	logic        tstep = 1'b0;
	logic        twr = 1'b0;
	logic [2:0]  tsel = 3'h0;
	logic [31:0] tdat = 32'h0;
	int          miscompares = 0;
	int          compares = 0;

	always #2 clk = ~clk;

	insn_sequencer dut (.sys_clk_i(clk), .rst_i(rst), .imem_addr_o(ia),
		.imem_req_o(ireq), .imem_rdata_i(ir), .op_o(op), .lit_o(lit),
		.uir_o(uir), .data_addr_o(da), .data_size_o(dsz), .data_req_o(dreq),
		.base_wr_i(bwr), .base_sel_i(bsel), .base_wdata_i(bwd),
		.uc_wr_i(ucw), .uc_waddr_i(ucwa), .uc_wdata_i(ucwd),
		.uc_raddr_i(ucra), .uc_rdata_o(ucr), .test_pin_i(tpin),
		.test_uir_wr_i(tuw), .test_step_i(tstep), .test_wr_i(twr),
		.test_sel_i(tsel), .test_data_i(tdat), .test_rdata_o(trd),
		.test_active_o(tact));

	prog_mem_model mem_u (.sys_clk_i(clk), .rst_i(rst), .addr_i(ia),
		.req_i(ireq), .rdata_o(ir));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] mk(input logic [8:0] o,
		input logic [20:0] f, input logic [1:0] c);
		return {o, f, c};
	endfunction

	task automatic give_verdict;
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// bounded wait for the next fetch request, then its address
	task automatic wait_req(input logic [31:0] a);
		int n;
		n = 0;
		@(negedge clk);
		while (ireq !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		if (n >= 30) begin
			miscompares++;
			give_verdict();
		end
		`CHK("imem_addr", a, ia)
	endtask

	task automatic uc_write(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		ucw = 1'b1;
		ucwa = a;
		ucwd = d;
		@(negedge clk);
		ucw = 1'b0;
	endtask

	task automatic t_write(input logic [2:0] s, input logic [31:0] d);
		@(negedge clk);
		twr = 1'b1;
		tsel = s;
		tdat = d;
		@(negedge clk);
		twr = 1'b0;
	endtask

	task automatic t_read(input logic [2:0] s, input logic [31:0] e);
		@(negedge clk);
		tsel = s;
		@(negedge clk);
		`CHK("test_rdata", e, trd)
	endtask

	////////////////////////////////////////////////////////////////////////
	// seq, call, ret, dual in one chain; ops hit both ends of the range
	task automatic fetch_flow;
		wait_req(32'h0000_0000);
		wait_req(32'h0000_0004);
		`CHK("op", 9'h1ff, op)
		`CHK("lit", 23'h70_0003, lit)
		wait_req(32'h0000_0040);
		`CHK("op", 9'h0a5, op)
		@(negedge clk);
		`CHK("uir", 32'h0000_00a5, uir)
		wait_req(32'h0000_0008);
		`CHK("op", 9'h15a, op)
		`CHK("uir", 32'h8000_01a5, uir)
		`CHK("lit", 23'h0f_ffff, lit)
		wait_req(32'h0000_000c);
		`CHK("op", 9'h000, op)
		`CHK("lit", 23'h7f_ffe1, lit)
		@(negedge clk);
		`CHK("op", 9'h100, op)
		`CHK("lit", 23'h00_001f, lit)
	endtask

	// store rewritten and read back while the program keeps running
	task automatic uc_port;
		uc_write({9'h055, 3'h2}, 32'h1234_5678);
		@(negedge clk);
		ucra = {9'h055, 3'h2};
		@(negedge clk);
		`CHK("uc_rdata", 32'h1234_5678, ucr)
		ucra = {9'h1ff, 3'h0};
		@(negedge clk);
		`CHK("uc_rdata", 32'h8000_01ff, ucr)
	endtask

	task automatic test_port;
		logic [31:0] d;
		int          n;
		n = 0;
		tpin = 1'b1;
		while (tact !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		`CHK("test_active", 1'b1, tact)
		for (int s = 0; s < 3; s++) begin
			d = {2'h3, 2'h0, s[1:0], 26'h0};
			@(negedge clk);
			tuw = 1'b1;
			tdat = d;
			@(negedge clk);
			tuw = 1'b0;
			`CHK("uir", d, uir)
			tstep = 1'b1;
			@(negedge clk);
			tstep = 1'b0;
			`CHK("data_req", 1'b1, dreq)
			`CHK("data_size", s[1:0], dsz)
		end
		t_write(TREG_BASE + 3'h1, 32'hcafe_0010);
		t_read(TREG_BASE + 3'h1, 32'hcafe_0010);
		t_write(TREG_BASE, 32'hffff_ffff);
		t_read(TREG_BASE, 32'h0000_0000);
		t_write(TREG_NAR, 32'h0000_0080);
		t_read(TREG_NAR, 32'h0000_0080);
		@(negedge clk);
		bwr = 1'b1;
		bsel = 2'h2;
		bwd = 32'h0000_1230;
		@(negedge clk);
		bsel = 2'h0;
		bwd = 32'h5555_5555;
		@(negedge clk);
		bwr = 1'b0;
		t_read(TREG_BASE + 3'h2, 32'h0000_1230);
		t_read(TREG_BASE, 32'h0000_0000);
		// last literal offered is zero: filler words carry an empty field
		@(negedge clk);
		tuw = 1'b1;
		tdat = {2'h3, 2'h2, SIZE_WORD, 26'h0};
		@(negedge clk);
		tuw = 1'b0;
		tstep = 1'b1;
		@(negedge clk);
		tstep = 1'b0;
		`CHK("data_addr", 32'h0000_1230, da)
		t_write(TREG_DADDR, 32'h0000_0102);
		`CHK("data_addr", 32'h0000_0102, da)
		tpin = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [8:0] ops [5];
		ops = '{9'h1ff, 9'h0a5, 9'h15a, 9'h000, 9'h100};
		for (int i = 0; i < 64; i++)
			mem_u.mem[i] = mk(9'h000, 21'h0, CTL_SEQ);
		mem_u.mem[0] = mk(9'h1ff, 21'h10_0003, CTL_SEQ);
		mem_u.mem[1] = mk(9'h0a5, 21'h00_0010, CTL_CALL);
		mem_u.mem[16] = mk(9'h15a, 21'h0f_ffff, CTL_RET);
		mem_u.mem[2] = {9'h000, 6'h21, 9'h100, 6'h1f, CTL_DUAL};
		mem_u.mem[3] = mk(9'h000, 21'h00_0005, CTL_SEQ);
		// one-step microcode, except a two-step call opcode; six writes
		// keep reset up for twelve clocks
		foreach (ops[i])
			uc_write({ops[i], 3'h0}, (ops[i] == 9'h0a5 ? 32'h0000_0000
				: 32'h8000_0000) | {23'h0, ops[i]});
		uc_write({9'h0a5, 3'h1}, 32'h8000_01a5);
		rst = 1'b0;
		fetch_flow();
		uc_port();
		test_port();
		give_verdict();
	end
endmodule
